/* ahp_host.sv */
// Host-side controller driving an ATA drive's PIO and multiword DMA pins
//
// Overview of operation
// RULE1: Drive handles passed-diagnostic direction; host only observes the line.
// RULE2: Host presents a three-bit register address on the address pins.
// RULE3: Chip select 0 picks command block registers, ports 1F0 to 1F7.
// RULE4: Chip select 1 picks control registers, ports 3F6 to 3F7.
// RULE5: Drive signals activity or device 1 present on open-collector line.
// RULE6: PIO cycles spaced at least 600/383/240/180/120 ns for modes 0-4.
// RULE7: PIO strobe held at least 165/125/100/80/70 ns for modes 0-4.
// RULE8: PIO modes 3 and 4 keep strobes negated 70 and 25 ns.
// RULE9: Drive releases ready within 1250 ns; host stretches strobe meanwhile.
// RULE10: DMA word cycles spaced at least 480/150/120 ns for modes 0-2.
// RULE11: DMA strobe held at least 215/80/70 ns for modes 0-2.
// RULE12: DMA read strobe negated at least 50/50/25 ns between words.
// RULE13: DMA write strobe negated at least 215/50/25 ns between words.
// RULE14: DMA acknowledge held 20/5/5 ns after the word's last strobe edge.
// RULE15: Drive raises DMA request when ready to move data.
// RULE16: Host asserts DMA acknowledge to move data the drive requested.
// RULE17: Drive may pull ready low to insert PIO wait states.
// RULE18: Both ends apply the configured PIO and DMA mode timing.
`timescale 1ns/1ps
`default_nettype none
module ahp_host
	import ahp_pkg::*;
(
	// Clock and reset
	input  wire logic              clk_sys_i,
	input  wire logic              rst_i,
	// Mode configuration
	input  wire logic [2:0]        pio_mode_i,
	input  wire logic [2:0]        dma_mode_i,
	// Command stream
	input  wire logic              cmd_valid_i,
	output logic                   cmd_ready_o,
	input  wire ahp_cmd_t          cmd_i,
	// Read data stream
	output logic                   rd_valid_o,
	input  wire logic              rd_ready_i,
	output logic      [DATA_W-1:0] rd_data_o,
	// Status
	output logic                   busy_o,
	output logic                   iordy_timeout_o,
	output logic                   drive_active_o,
	output logic                   diag_passed_o,
	// Drive data bus
	input  wire logic [DATA_W-1:0] dd_i,
	output logic      [DATA_W-1:0] dd_o,
	output logic                   dd_oe_o,
	// Drive control pins
	output logic      [2:0]        da_o,
	output logic                   cs0_n_o,
	output logic                   cs1_n_o,
	output logic                   dior_n_o,
	output logic                   diow_n_o,
	output logic                   dmack_n_o,
	input  wire logic              iordy_i,
	input  wire logic              dmarq_i,
	input  wire logic              dasp_n_i,
	input  wire logic              pdiag_n_i
);

	// ----------------------------------------------------------------
	// State and registers
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE   = 2'h0,
		ST_SETUP  = 2'h1,
		ST_ACTIVE = 2'h3,
		ST_RECOV  = 2'h2
	} ahp_state_t;

	ahp_state_t       state;
	ahp_state_t       next_state;
	ahp_cmd_t         cur;
	logic [2:0]       pio_mode;
	logic [2:0]       dma_mode;
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] next_cnt;
	logic [CNT_W-1:0] wait_cnt;
	logic             fifo_in_ready;

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	wire ahp_tim_t cur_tim  = ahp_timing(cur.dma, cur.write, cur.dma ? dma_mode : pio_mode);
	wire ahp_tim_t new_tim  = ahp_timing(cmd_i.dma, cmd_i.write, cmd_i.dma ? dma_mode_i : pio_mode_i);
	wire           cnt_done = (cnt == '0);
	wire           cmd_ok   = (cmd_i.write || fifo_in_ready) && (!cmd_i.dma || dmarq_i);
	// Only a same-direction DMA word may reuse the held acknowledge
	wire           dma_cont = cur.dma && cmd_i.dma && (cmd_i.write == cur.write) && cmd_ok;
	wire           at_idle  = (state == ST_IDLE);
	wire           at_rend  = (state == ST_RECOV) && cnt_done;
	wire           wait_out = (wait_cnt >= CNT_W'(IORDY_MAX_CYC));
	// Ready stretches the strobe only in PIO
	wire           rdy_ok   = cur.dma || iordy_i || wait_out; // RULE9 RULE17
	wire           act_end  = (state == ST_ACTIVE) && cnt_done && rdy_ok;
	wire           rd_push  = act_end && !cur.write;

	assign cmd_ready_o = cmd_ok && (at_idle || (at_rend && dma_cont)); // RULE15 RULE16
	wire           take     = cmd_valid_i && cmd_ready_o;

	always_comb begin
		next_state = state;
		next_cnt   = cnt_done ? cnt : CNT_W'(cnt - 1'b1);
		case (state)
			ST_IDLE: begin
				if (take) begin
					next_state = ST_SETUP;
					next_cnt   = CNT_W'(new_tim.setup - 1'b1);
				end
			end
			ST_SETUP: begin
				if (cnt_done) begin
					next_state = ST_ACTIVE;
					next_cnt   = CNT_W'(cur_tim.active - 1'b1); // RULE7 RULE11
				end
			end
			ST_ACTIVE: begin
				if (act_end) begin
					next_state = ST_RECOV;
					next_cnt   = CNT_W'(cur_tim.recov - 1'b1); // RULE6 RULE8 RULE10 RULE12 RULE13
				end
			end
			ST_RECOV: begin
				if (cnt_done) begin
					next_state = take ? ST_ACTIVE : ST_IDLE;
					next_cnt   = CNT_W'(new_tim.active - 1'b1);
				end
			end
			default: begin
				next_state = ST_IDLE;
				next_cnt   = '0;
			end
		endcase
	end

	wire next_strobe = (next_state == ST_ACTIVE);
	wire next_dmack  = take ? cmd_i.dma : (cur.dma && (next_state != ST_IDLE)); // RULE14 RULE16
	wire next_drive  = (next_state != ST_IDLE) && (take ? cmd_i.write : cur.write);

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			state <= ST_IDLE;
			cnt   <= '0;
			cur   <= '0;
		end else begin
			state <= next_state;
			cnt   <= next_cnt;
			cur   <= take ? cmd_i : cur;
		end
	end

	// Modes change only between transfers so both ends agree on timing
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			pio_mode <= '0;
			dma_mode <= '0;
		end else if (at_idle) begin
			pio_mode <= pio_mode_i; // RULE18
			dma_mode <= dma_mode_i; // RULE18
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			wait_cnt <= '0;
		end else begin
			wait_cnt <= ((state == ST_ACTIVE) && cnt_done && !iordy_i && !wait_out) ?
				CNT_W'(wait_cnt + 1'b1) : ((state == ST_ACTIVE) ? wait_cnt : '0);
		end
	end

	// ----------------------------------------------------------------
	// Pin drivers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			dior_n_o  <= 1'b1;
			diow_n_o  <= 1'b1;
			dmack_n_o <= 1'b1;
			cs0_n_o   <= 1'b1;
			cs1_n_o   <= 1'b1;
			da_o      <= '0;
			dd_o      <= '0;
			dd_oe_o   <= 1'b0;
		end else begin
			dior_n_o  <= !(next_strobe && !(take ? cmd_i.write : cur.write));
			diow_n_o  <= !(next_strobe && (take ? cmd_i.write : cur.write));
			dmack_n_o <= !next_dmack;
			if (take) begin
				cs0_n_o <= cmd_i.dma || cmd_i.ctrl_blk; // RULE3
				cs1_n_o <= cmd_i.dma || !cmd_i.ctrl_blk; // RULE4
				da_o    <= cmd_i.addr; // RULE2
				dd_o    <= cmd_i.data;
			end else if (next_state == ST_IDLE) begin
				cs0_n_o <= 1'b1;
				cs1_n_o <= 1'b1;
			end
			dd_oe_o   <= next_drive;
		end
	end

	// ----------------------------------------------------------------
	// Status
	// ----------------------------------------------------------------
	// Both lines belong to the drives; the host never drives them
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			iordy_timeout_o <= 1'b0;
			drive_active_o  <= 1'b0;
			diag_passed_o   <= 1'b0;
		end else begin
			iordy_timeout_o <= act_end && !cur.dma && wait_out && !iordy_i; // RULE9
			drive_active_o  <= !dasp_n_i; // RULE5
			diag_passed_o   <= !pdiag_n_i; // RULE1
		end
	end

	assign busy_o = !at_idle;

	// ----------------------------------------------------------------
	// Read buffer
	// ----------------------------------------------------------------
	ahp_fifo #(
		.WIDTH (DATA_W),
		.DEPTH (FIFO_DEPTH)
	) u_rd_fifo (
		.clk_sys_i   (clk_sys_i),
		.rst_i       (rst_i),
		.in_valid_i  (rd_push),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   (dd_i),
		.out_valid_o (rd_valid_o),
		.out_ready_i (rd_ready_i),
		.out_data_o  (rd_data_o)
	);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	wire        strobe_n = dior_n_o && diow_n_o;
	logic [7:0] low_len;
	logic [7:0] high_len;
	logic [7:0] period;
	logic       seen;

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			low_len  <= '0;
			high_len <= '0;
			period   <= '0;
			seen     <= 1'b0;
		end else begin
			low_len  <= strobe_n ? '0 : 8'(low_len + 1'b1);
			high_len <= !strobe_n ? '0 : ((high_len == 8'hFF) ? high_len : 8'(high_len + 1'b1));
			period   <= $fell(strobe_n) ? 8'h01 : ((period == 8'hFF) ? period : 8'(period + 1'b1));
			seen     <= seen || !strobe_n;
		end
	end

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);

	a_strobe_width: assert property ($rose(strobe_n) |-> low_len >= 8'(cur_tim.active)) // RULE7 RULE11
		else $error("Strobe shorter than mode minimum");
	a_cycle_spacing: assert property ($fell(strobe_n) && seen && !cur.dma |-> period >= 8'(cur_tim.cycle)) // RULE6
		else $error("PIO cycles too close");
	a_dma_spacing: assert property ($fell(strobe_n) && $past(!dmack_n_o) && cur.dma
		|-> period >= 8'(cur_tim.cycle)) // RULE10
		else $error("DMA words too close");
	a_strobe_recovery: assert property ($fell(strobe_n) && seen |-> high_len >= 8'(cur_tim.recov)) // RULE8 RULE12 RULE13
		else $error("Strobe recovery too short");
	a_dmack_hold: assert property ($rose(dmack_n_o) |-> $past(strobe_n)) // RULE14
		else $error("Acknowledge dropped with strobe");
	a_dmack_request: assert property ($fell(dmack_n_o) |-> $past(dmarq_i, 1)) // RULE16
		else $error("Acknowledge without request");
	a_cs_exclusive: assert property (!(cs0_n_o == 1'b0 && cs1_n_o == 1'b0)) // RULE3 RULE4
		else $error("Both chip selects active");
	a_addr_stable: assert property (!strobe_n && $past(!strobe_n) |-> $stable(da_o) && $stable(cs0_n_o)) // RULE2
		else $error("Address moved under strobe");
	a_ready_stretch: assert property (state == ST_ACTIVE && cnt_done && !cur.dma && !iordy_i && !wait_out
		|=> !strobe_n) // RULE9 RULE17
		else $error("Strobe ended while ready withheld");
	a_mode_stable: assert property (busy_o && $past(busy_o) |-> $stable(pio_mode) && $stable(dma_mode)) // RULE18
		else $error("Mode changed during transfer");

	c_pio_read: cover property ($rose(dior_n_o) && dmack_n_o);
	c_pio_write: cover property ($rose(diow_n_o) && dmack_n_o);
	c_dma_burst: cover property (!dmack_n_o && $fell(strobe_n) && $past(!dmack_n_o, 2));
	c_ready_wait: cover property (state == ST_ACTIVE && cnt_done && !iordy_i ##1 iordy_i);

endmodule : ahp_host
`default_nettype wire

/* ahp_pkg.sv */
// Shared constants, timing tables and carrier types for the ATA host port
package ahp_pkg;

	// ----------------------------------------------------------------
	// Clock and sizes
	// ----------------------------------------------------------------
	localparam int CLK_NS     = 50;
	localparam int DATA_W     = 16;
	localparam int FIFO_DEPTH = 16;
	localparam int CNT_W      = 5;
	localparam int PIO_MAX    = 4;
	localparam int DMA_MAX    = 2;

	// ----------------------------------------------------------------
	// Timing tables in ns, indexed by mode
	// ----------------------------------------------------------------
	localparam int PIO_T0_NS  [5] = '{600, 383, 240, 180, 120};
	localparam int PIO_T1_NS  [5] = '{70, 50, 30, 30, 25};
	localparam int PIO_T2_NS  [5] = '{165, 125, 100, 80, 70};
	localparam int PIO_T2I_NS [5] = '{0, 0, 0, 70, 25};
	localparam int PIO_T9_NS  [5] = '{20, 15, 10, 10, 10};
	localparam int DMA_T0_NS  [3] = '{480, 150, 120};
	localparam int DMA_TD_NS  [3] = '{215, 80, 70};
	localparam int DMA_TKR_NS [3] = '{50, 50, 25};
	localparam int DMA_TKW_NS [3] = '{215, 50, 25};
	localparam int DMA_TJ_NS  [3] = '{20, 5, 5};
	localparam int IORDY_MAX_NS   = 1250;
	// Longest time, so rounded down
	localparam int IORDY_MAX_CYC  = IORDY_MAX_NS / CLK_NS;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic              write;
		logic              dma;
		logic              ctrl_blk;
		logic [2:0]        addr;
		logic [DATA_W-1:0] data;
	} ahp_cmd_t;

	typedef struct packed {
		logic [CNT_W-1:0] setup;
		logic [CNT_W-1:0] active;
		logic [CNT_W-1:0] recov;
		logic [CNT_W-1:0] cycle;
	} ahp_tim_t;

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	// Least times round up, never below one cycle
	function automatic int ahp_min_cyc(input int ns);
		int c;
		c = (ns + CLK_NS - 1) / CLK_NS;
		return (c < 1) ? 1 : c;
	endfunction : ahp_min_cyc

	function automatic int ahp_max3(input int a, input int b, input int c);
		int m;
		m = (a > b) ? a : b;
		return (m > c) ? m : c;
	endfunction : ahp_max3

	function automatic ahp_tim_t ahp_timing(input logic dma, input logic write, input logic [2:0] mode);
		int m;
		int t0;
		int act;
		int set;
		int rec;
		ahp_tim_t t;
		if (dma) begin
			m   = (int'(mode) > DMA_MAX) ? DMA_MAX : int'(mode);
			t0  = ahp_min_cyc(DMA_T0_NS[m]);
			act = ahp_min_cyc(DMA_TD_NS[m]);
			set = 1;
			rec = ahp_max3(t0 - act, ahp_min_cyc(write ? DMA_TKW_NS[m] : DMA_TKR_NS[m]),
				ahp_min_cyc(DMA_TJ_NS[m]));
		end else begin
			m   = (int'(mode) > PIO_MAX) ? PIO_MAX : int'(mode);
			t0  = ahp_min_cyc(PIO_T0_NS[m]);
			act = ahp_min_cyc(PIO_T2_NS[m]);
			set = ahp_min_cyc(PIO_T1_NS[m]);
			rec = ahp_max3(t0 - set - act, (PIO_T2I_NS[m] > 0) ? ahp_min_cyc(PIO_T2I_NS[m]) : 1,
				ahp_min_cyc(PIO_T9_NS[m]));
		end
		t.setup  = CNT_W'(set);
		t.active = CNT_W'(act);
		t.recov  = CNT_W'(rec);
		t.cycle  = CNT_W'(t0);
		return t;
	endfunction : ahp_timing

endpackage : ahp_pkg

/* ahp_fifo.sv */
// Synchronous valid/ready FIFO held in flip-flops
`timescale 1ns/1ps
`default_nettype none
module ahp_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input  wire logic             clk_sys_i,
	input  wire logic             rst_i,
	// Fill side
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	// Drain side
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	wire              push = in_valid_i && in_ready_o;
	wire              pop  = out_valid_o && out_ready_i;

	assign in_ready_o  = (count != (AW+1)'(DEPTH));
	assign out_valid_o = (count != '0);
	assign out_data_o  = mem[rd_ptr];

	always_ff @(posedge clk_sys_i) begin
		if (push) begin
			mem[wr_ptr] <= in_data_i;
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			wr_ptr <= push ? AW'(wr_ptr + 1'b1) : wr_ptr;
			rd_ptr <= pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
			count  <= (AW+1)'(count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
		end
	end

endmodule : ahp_fifo
`default_nettype wire

/* ahp_drv_model.sv */
// Behavioural ATA drive model that answers the host port and checks host timing
`timescale 1ns/1ps
`default_nettype none
module ahp_drv_model
	import ahp_pkg::*;
(
	// Host pins
	input  wire logic [DATA_W-1:0] dd_h_i,
	input  wire logic              dd_oe_i,
	input  wire logic [2:0]        da_i,
	input  wire logic              cs0_n_i,
	input  wire logic              cs1_n_i,
	input  wire logic              dior_n_i,
	input  wire logic              diow_n_i,
	input  wire logic              dmack_n_i,
	output logic      [DATA_W-1:0] dd_o,
	output logic                   iordy_o,
	output logic                   dmarq_o,
	output logic                   dasp_n_o,
	output logic                   pdiag_n_o,
	// Bench controls
	input  wire logic [2:0]        pio_mode_i,
	input  wire logic [2:0]        dma_mode_i,
	input  wire logic [7:0]        wait_cyc_i,
	input  wire logic              req_i,
	input  wire logic              active_i,
	input  wire logic              diag_i,
	output logic      [7:0]        viol_o
);
	logic [DATA_W-1:0] cmd_reg [8];
	logic [DATA_W-1:0] ctl_reg [2];
	logic [DATA_W-1:0] dmem    [16];
	logic [DATA_W-1:0] last;
	logic [DATA_W-1:0] rd_val;
	logic [3:0]        wp, rp;
	logic              pio_rd, dma_rd;
	int                pm, dm;
	realtime           t_fall, t_rise;

	initial begin
		wp = 4'h0;
		rp = 4'h0;
		viol_o = 8'h00;
		iordy_o = 1'b1;
		t_fall = -1.0e6;
		t_rise = -1.0e6;
	end
	assign pm = (pio_mode_i > 3'h4) ? 4 : int'(pio_mode_i);
	assign dm = (dma_mode_i > 3'h2) ? 2 : int'(dma_mode_i);
	assign dmarq_o = req_i;
	assign dasp_n_o = active_i ? 1'b0 : 1'b1;
	assign pdiag_n_o = !diag_i;
	// ----------------------------------------------------------------
	// Bus level; a released bus shows the inverse of its last value
	// ----------------------------------------------------------------
	assign pio_rd = !dior_n_i && dmack_n_i && !(cs0_n_i && cs1_n_i);
	assign dma_rd = !dior_n_i && !dmack_n_i;
	assign rd_val = dma_rd ? dmem[rp] : (!cs0_n_i ? cmd_reg[da_i] : ctl_reg[da_i[0]]);
	assign dd_o = dd_oe_i ? dd_h_i : ((pio_rd || dma_rd) ? rd_val : ~last);
	always @(dd_o) if (dd_oe_i || pio_rd || dma_rd) last = dd_o;
	always @(posedge diow_n_i) if ($realtime > 0) begin
		if (!dmack_n_i) begin
			dmem[wp] = dd_o;
			wp = wp + 4'h1;
		end else if (!cs0_n_i) cmd_reg[da_i] = dd_o;
		else if (!cs1_n_i) ctl_reg[da_i[0]] = dd_o;
	end
	// Data port advances on every read so FIFO order shows
	always @(posedge dior_n_i) if ($realtime > 0) begin
		if (!dmack_n_i) rp = rp + 4'h1;
		else if (!cs0_n_i && da_i == 3'h0) cmd_reg[0] = cmd_reg[0] + 16'h0001;
	end
	always @(negedge dior_n_i or negedge diow_n_i) if (dmack_n_i && wait_cyc_i != 8'h00) begin
		iordy_o = 1'b0;
		// Release half a cycle early so ready never moves on a host sampling edge
		#(CLK_NS * wait_cyc_i - CLK_NS / 2);
		iordy_o = 1'b1;
	end
	// ----------------------------------------------------------------
	// Host timing limits of the selected modes
	// ----------------------------------------------------------------
	always @(negedge dior_n_i or negedge diow_n_i) begin
		if ($realtime - t_fall < (!dmack_n_i ? DMA_T0_NS[dm] : PIO_T0_NS[pm])) viol_o = viol_o + 8'h01;
		if ($realtime - t_rise < (!dmack_n_i ? (diow_n_i ? DMA_TKR_NS[dm] : DMA_TKW_NS[dm]) : PIO_T2I_NS[pm]))
			viol_o = viol_o + 8'h01;
		t_fall = $realtime;
	end
	always @(posedge dior_n_i or posedge diow_n_i) if ($realtime > 0) begin
		if ($realtime - t_fall < (!dmack_n_i ? DMA_TD_NS[dm] : PIO_T2_NS[pm])) viol_o = viol_o + 8'h01;
		t_rise = $realtime;
	end
	always @(posedge dmack_n_i) if ($realtime > CLK_NS && $realtime - t_rise < DMA_TJ_NS[dm]) viol_o = viol_o + 8'h01;
endmodule : ahp_drv_model
`default_nettype wire

/* tb_ahp_host.sv */
// Self-checking testbench for the ATA host port controller
`timescale 1ns/1ps
`default_nettype none
module tb_ahp_host
	import ahp_pkg::*;
;
	logic clk_sys_i, rst_i, cmd_valid, rd_ready, busy, tmo, act_o, diag_o, rd_valid, cmd_ready;
	logic dd_oe, cs0_n, cs1_n, dior_n, diow_n, dmack_n, iordy, dmarq, dasp_n, pdiag_n;
	logic req, active, diag;
	logic [2:0] pio_mode, dma_mode, da;
	logic [7:0] wait_cyc, viol;
	logic [DATA_W-1:0] rd_data, dd_h, dd_w;
	ahp_cmd_t cmd;
	int num_errors, n_tests, n_to;

	ahp_host i_ahp_host (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .pio_mode_i(pio_mode), .dma_mode_i(dma_mode),
		.cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_i(cmd), .rd_valid_o(rd_valid),
		.rd_ready_i(rd_ready), .rd_data_o(rd_data), .busy_o(busy), .iordy_timeout_o(tmo),
		.drive_active_o(act_o), .diag_passed_o(diag_o), .dd_i(dd_w), .dd_o(dd_h), .dd_oe_o(dd_oe),
		.da_o(da), .cs0_n_o(cs0_n), .cs1_n_o(cs1_n), .dior_n_o(dior_n), .diow_n_o(diow_n),
		.dmack_n_o(dmack_n), .iordy_i(iordy), .dmarq_i(dmarq), .dasp_n_i(dasp_n), .pdiag_n_i(pdiag_n));
	ahp_drv_model i_ahp_drv_model (.dd_h_i(dd_h), .dd_oe_i(dd_oe), .da_i(da), .cs0_n_i(cs0_n), .cs1_n_i(cs1_n),
		.dior_n_i(dior_n), .diow_n_i(diow_n), .dmack_n_i(dmack_n), .dd_o(dd_w), .iordy_o(iordy),
		.dmarq_o(dmarq), .dasp_n_o(dasp_n), .pdiag_n_o(pdiag_n), .pio_mode_i(pio_mode), .dma_mode_i(dma_mode),
		.wait_cyc_i(wait_cyc), .req_i(req), .active_i(active), .diag_i(diag), .viol_o(viol));

	initial begin
		clk_sys_i = 1'b0;
		forever #25 clk_sys_i = ~clk_sys_i;
	end
	always @(posedge clk_sys_i) if (tmo === 1'b1) n_to++;
	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic tally_and_finish;
		$display("errors %0d tests %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic send(input logic w, input logic d, input logic b, input logic [2:0] a, input logic [15:0] x);
		int k;
		k = 0;
		@(negedge clk_sys_i);
		cmd_valid = 1'b1;
		cmd = '{w, d, b, a, x};
		#1;
		while (cmd_ready !== 1'b1 && k < 400) begin
			@(negedge clk_sys_i);
			#1;
			k++;
		end
		if (k == 400) chk(16'h0001, 16'h0000);
		@(posedge clk_sys_i);
	endtask : send
	task automatic finish_op;
		int k;
		@(negedge clk_sys_i);
		cmd_valid = 1'b0;
		for (k = 0; k < 200 && busy !== 1'b0; k++) @(negedge clk_sys_i);
		chk(16'(busy), 16'h0000);
	endtask : finish_op
	task automatic pio(input logic w, input logic b, input logic [2:0] a, input logic [15:0] x);
		send(w, 1'b0, b, a, x);
		finish_op();
	endtask : pio
	task automatic pop(input logic [15:0] exp);
		int k;
		@(negedge clk_sys_i);
		for (k = 0; k < 100 && rd_valid !== 1'b1; k++) @(negedge clk_sys_i);
		chk(rd_data, exp);
		rd_ready = 1'b1;
		@(negedge clk_sys_i);
		rd_ready = 1'b0;
	endtask : pop
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		chk({cs0_n, cs1_n, dior_n, diow_n, dmack_n, dd_oe, busy, rd_valid}, 16'h00F8);
	endtask : t_reset
	task automatic t_pio_modes;
		for (int m = 0; m < 5; m++) begin
			pio_mode = 3'(m);
			repeat (20) @(negedge clk_sys_i);
			for (int a = 1; a < 8; a++) pio(1'b1, 1'b0, 3'(a), 16'hA000 + 16'(m * 16 + a));
			pio(1'b1, 1'b1, 3'h6, 16'hC060 + 16'(m));
			pio(1'b1, 1'b1, 3'h7, 16'hC070 + 16'(m));
			for (int a = 1; a < 8; a++) begin
				pio(1'b0, 1'b0, 3'(a), 16'h0000);
				pop(16'hA000 + 16'(m * 16 + a));
			end
			pio(1'b0, 1'b1, 3'h6, 16'h0000);
			pop(16'hC060 + 16'(m));
			pio(1'b0, 1'b1, 3'h7, 16'h0000);
			pop(16'hC070 + 16'(m));
		end
	endtask : t_pio_modes
	task automatic t_fifo;
		pio(1'b1, 1'b0, 3'h0, 16'h5000);
		for (int i = 0; i < 16; i++) pio(1'b0, 1'b0, 3'h0, 16'h0000);
		@(negedge clk_sys_i);
		cmd_valid = 1'b1;
		cmd = '{1'b0, 1'b0, 1'b0, 3'h0, 16'h0000};
		// A full FIFO must hold the read off, not drop it
		repeat (10) begin
			#1 chk(16'(cmd_ready), 16'h0000);
			@(negedge clk_sys_i);
		end
		cmd_valid = 1'b0;
		for (int i = 0; i < 16; i++) pop(16'h5000 + 16'(i));
		chk(16'(rd_valid), 16'h0000);
	endtask : t_fifo
	task automatic t_iordy;
		pio_mode = 3'h2;
		pio(1'b1, 1'b1, 3'h6, 16'h0066);
		wait_cyc = 8'd10;
		pio(1'b0, 1'b1, 3'h6, 16'h0000);
		pop(16'h0066);
		chk(16'(n_to), 16'h0000);
		wait_cyc = 8'd40;
		pio(1'b0, 1'b1, 3'h6, 16'h0000);
		pop(16'h0066);
		chk(16'(n_to), 16'h0001);
		wait_cyc = 8'd0;
		repeat (40) @(negedge clk_sys_i);
	endtask : t_iordy
	task automatic t_dma;
		req = 1'b0;
		@(negedge clk_sys_i);
		cmd_valid = 1'b1;
		cmd = '{1'b1, 1'b1, 1'b0, 3'h0, 16'hDEAD};
		repeat (5) begin
			#1 chk(16'(cmd_ready), 16'h0000);
			@(negedge clk_sys_i);
		end
		cmd_valid = 1'b0;
		req = 1'b1;
		send(1'b1, 1'b1, 1'b0, 3'h0, 16'hDEAD);
		finish_op();
		send(1'b0, 1'b1, 1'b0, 3'h0, 16'h0000);
		finish_op();
		pop(16'hDEAD);
		for (int m = 0; m < 3; m++) begin
			dma_mode = 3'(m);
			repeat (20) @(negedge clk_sys_i);
			for (int i = 0; i < 3; i++) send(1'b1, 1'b1, 1'b0, 3'h0, 16'hD000 + 16'(m * 16 + i));
			finish_op();
			for (int i = 0; i < 3; i++) send(1'b0, 1'b1, 1'b0, 3'h0, 16'h0000);
			finish_op();
			for (int i = 0; i < 3; i++) pop(16'hD000 + 16'(m * 16 + i));
		end
		req = 1'b0;
	endtask : t_dma
	task automatic t_status;
		active = 1'b1;
		diag = 1'b1;
		repeat (3) @(negedge clk_sys_i);
		chk({act_o, diag_o}, 16'h0003);
		active = 1'b0;
		diag = 1'b0;
		repeat (3) @(negedge clk_sys_i);
		chk({act_o, diag_o}, 16'h0000);
	endtask : t_status
	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		{num_errors, n_tests, n_to} = '0;
		{rst_i, cmd_valid, rd_ready, req, active, diag} = 6'b100000;
		{pio_mode, dma_mode, wait_cyc} = '0;
		cmd = '0;
		repeat (3) @(posedge clk_sys_i);
		t_reset();
		@(negedge clk_sys_i);
		rst_i = 1'b0;
		t_reset();
		t_pio_modes();
		t_fifo();
		t_iordy();
		t_dma();
		t_status();
		chk(16'(viol), 16'h0000);
		tally_and_finish();
	end
	initial begin
		#(CLK_NS * 60000);
		num_errors++;
		$display("[FAIL] %0t watchdog expired", $time);
		tally_and_finish();
	end
endmodule : tb_ahp_host
`default_nettype wire
